// file: logic/irq_ctrl.sv
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/10ps
// Prioritised interrupt controller with standby release and DMA trigger.
module irq_ctrl
  import irq_ctrl_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [N_EXT-1:0] ext_pins,
  input wire logic [N_KEY-1:0] key_pins,
  input wire logic [N_PERIPH-1:0] periph_irq,
  input wire logic core_ack,
  output core_req_t core_req,
  output dma_req_t dma_req,
  output logic standby_release
);
  // Pin synchronisers; stage one is read only by stage two.
  logic [N_EXT-1:0] ext_s1_q;
  logic [N_EXT-1:0] ext_s2_q;
  logic [N_KEY-1:0] key_s1_q;
  logic [N_KEY-1:0] key_s2_q;

  // Bus slave state.
  logic waitrequest_q; // High while the slave holds the master.
  logic waitrequest_d;
  logic [31:0] readdata_q; // Read data, valid with waitrequest low.
  logic [31:0] readdata_d;
  logic wr_fire; // Write takes effect at this edge.

  // Per source configuration and pending flags.
  logic [N_SRC-1:0][LVL_W-1:0] level_q;
  logic [N_SRC-1:0][LVL_W-1:0] level_d;
  logic [N_SRC-1:0][1:0] detect_q;
  logic [N_SRC-1:0][1:0] detect_d;
  logic [N_SRC-1:0] dma_en_q;
  logic [N_SRC-1:0] dma_en_d;
  logic [N_SRC-1:0] pending_q;
  logic [N_SRC-1:0] pending_d;
  logic [N_SRC-1:0] hit; // Detector outputs.
  logic [N_SRC-1:0] enabled_pend; // Pending with a nonzero level.

  // Standby release side.
  logic [N_WAKE-1:0][1:0] wake_sel_q;
  logic [N_WAKE-1:0][1:0] wake_sel_d;
  logic [N_WAKE-1:0][1:0] wake_req_q;
  logic [N_WAKE-1:0][1:0] wake_req_d;
  logic [N_WAKE-1:0] wake_en_q;
  logic [N_WAKE-1:0] wake_en_d;
  logic [N_WAKE-1:0] wake_pend_q;
  logic [N_WAKE-1:0] wake_pend_d;
  logic [N_WAKE-1:0] wake_hit;
  logic [N_KEY-1:0] key_en_q;
  logic [N_KEY-1:0] key_en_d;
  logic key_any; // Any enabled key input high.
  logic standby_release_q;
  logic standby_release_d;

  // Core side state.
  logic [31-VB_BASE_LSB:0] base_q; // Jump table base.
  logic [31-VB_BASE_LSB:0] base_d;
  logic [LVL_W-1:0] mask_q; // Current mask level.
  logic [LVL_W-1:0] mask_d;
  logic [STACK_DEPTH-1:0][LVL_W-1:0] stack_q; // Saved mask levels.
  logic [STACK_DEPTH-1:0][LVL_W-1:0] stack_d;
  logic [SP_W-1:0] sp_q; // Entries in the save stack.
  logic [SP_W-1:0] sp_d;
  logic in_service_q;
  logic in_service_d;
  logic nested_q; // Software allows nested interrupts.
  logic nested_d;
  core_req_t core_req_q;
  core_req_t core_req_d;
  dma_req_t dma_req_q;
  dma_req_t dma_req_d;
  logic found;
  logic [IDX_W-1:0] best_idx;
  logic [LVL_W-1:0] best_level;

  // Address decode helpers.
  logic src_hit; // Address falls on a source control word.
  logic [IDX_W-1:0] src_idx;
  logic wake_hit_adr; // Address falls on a standby control word.
  logic [3:0] wake_idx;
  logic [IDX_W-1:0] clr_idx; // Source named by a factor clear write.

  assign src_idx = address[8:2];
  assign src_hit = (address[11:9] == OFS_SRC_BASE[11:9]) && (src_idx < IDX_W'(N_SRC));
  assign wake_idx = address[5:2];
  assign wake_hit_adr = (address[11:6] == OFS_WAKE_BASE[11:6]) && (wake_idx < 4'(N_WAKE));
  assign clr_idx = writedata[8:2];
  // Only whole-word writes are honoured; partial lanes are dropped.
  assign wr_fire = write && !waitrequest_q && (byteenable == 4'hF);
  assign key_any = |(key_pins_gated(key_s2_q, key_en_q));

  function automatic logic [N_KEY-1:0] key_pins_gated(input logic [N_KEY-1:0] k,
                                                      input logic [N_KEY-1:0] e);
    key_pins_gated = k & e;
  endfunction

  // Two-stage synchronisers for everything arriving on a pin.
  always_ff @(posedge clock) begin
    if (reset) begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
      key_s1_q <= '0;
      key_s2_q <= '0;
    end else begin
      ext_s1_q <= ext_pins;
      ext_s2_q <= ext_s1_q;
      key_s1_q <= key_pins;
      key_s2_q <= key_s1_q;
    end
  end

  // One detector per source; peripherals always signal by falling edge.
  for (genvar i = 0; i < N_SRC; i++) begin : g_src
    logic smp;
    logic [1:0] mode;
    if (i == 0) begin : g_soft
      assign smp = 1'b0;
      assign mode = DET_HIGH;
    end else if (i < SRC_KEY) begin : g_ext
      assign smp = ext_s2_q[i-SRC_EXT0];
      assign mode = detect_q[i];
    end else if (i == SRC_KEY) begin : g_key
      assign smp = key_any;
      assign mode = detect_q[i];
    end else begin : g_per
      assign smp = periph_irq[i-SRC_PER0];
      assign mode = DET_FALL;
    end
    irq_detect u_det (
      .clock(clock),
      .reset(reset),
      .sample(smp),
      .mode(mode),
      .hit(hit[i])
    );
    assign enabled_pend[i] = pending_q[i] && (level_q[i] != LVL_OFF);
  end

  // Standby-side detectors for the twelve pins and the key wakeup.
  for (genvar w = 0; w < N_WAKE; w++) begin : g_wake
    irq_detect u_wdet (
      .clock(clock),
      .reset(reset),
      .sample((w < N_EXT) ? ext_s2_q[w % N_EXT] : key_any),
      .mode(wake_sel_q[w]),
      .hit(wake_hit[w])
    );
  end

  irq_arbiter u_arb (
    .pending(enabled_pend),
    .level(level_q),
    .found(found),
    .best_idx(best_idx),
    .best_level(best_level)
  );

  // Bus slave: one wait cycle, then data and completion together.
  always_comb begin
    waitrequest_d = 1'b1;
    readdata_d = readdata_q;
    if ((read || write) && waitrequest_q) begin
      waitrequest_d = 1'b0;
      readdata_d = 32'h0000_0000;
      if (read) begin
        // Unmapped addresses read as zero.
        if (src_hit) begin
          readdata_d[SC_LEVEL_LSB +: LVL_W] = level_q[src_idx];
          readdata_d[SC_DETECT_LSB +: 2] = detect_q[src_idx];
          readdata_d[SC_DMA_BIT] = dma_en_q[src_idx];
          readdata_d[SC_PEND_BIT] = pending_q[src_idx];
        end else if (wake_hit_adr) begin
          readdata_d[WK_SEL_LSB +: 2] = wake_sel_q[wake_idx];
          readdata_d[WK_REQ_LSB +: 2] = wake_req_q[wake_idx];
          readdata_d[WK_EN_BIT] = wake_en_q[wake_idx];
          readdata_d[WK_PEND_BIT] = wake_pend_q[wake_idx];
        end else begin
          case (address)
            OFS_VECTOR: readdata_d = {base_q, core_req_q.vector};
            OFS_LEVEL: readdata_d[LVL_W-1:0] = mask_q;
            OFS_CONTROL: begin
              readdata_d[CT_NEST_BIT] = nested_q;
              readdata_d[CT_INSVC_BIT] = in_service_q;
            end
            OFS_KEY_ENABLE: readdata_d[N_KEY-1:0] = key_en_q;
            default: readdata_d = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h0000_0000;
    end else begin
      waitrequest_q <= waitrequest_d;
      readdata_q <= readdata_d;
    end
  end

  // Source configuration and pending flags; a new hit beats a clear.
  always_comb begin
    level_d = level_q;
    detect_d = detect_q;
    dma_en_d = dma_en_q;
    pending_d = pending_q;
    if (wr_fire && src_hit) begin
      level_d[src_idx] = writedata[SC_LEVEL_LSB +: LVL_W];
      detect_d[src_idx] = writedata[SC_DETECT_LSB +: 2];
      dma_en_d[src_idx] = writedata[SC_DMA_BIT];
    end
    if (wr_fire && (address == OFS_FACTOR_CLEAR) && (writedata[1:0] == 2'h0)
        && (clr_idx < IDX_W'(N_SRC))) begin
      pending_d[clr_idx] = 1'b0;
    end
    pending_d = pending_d | hit;
    // Software set source fires on any nonzero level write.
    if (wr_fire && src_hit && (src_idx == '0)
        && (writedata[SC_LEVEL_LSB +: LVL_W] != LVL_OFF)) begin
      pending_d[0] = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      level_q <= '0;
      detect_q <= '0;
      dma_en_q <= '0;
      pending_q <= '0;
    end else begin
      level_q <= level_d;
      detect_q <= detect_d;
      dma_en_q <= dma_en_d;
      pending_q <= pending_d;
    end
  end

  // Standby release: pending is caught only while the request is active.
  always_comb begin
    wake_sel_d = wake_sel_q;
    wake_req_d = wake_req_q;
    wake_en_d = wake_en_q;
    wake_pend_d = wake_pend_q;
    key_en_d = key_en_q;
    if (wr_fire && wake_hit_adr) begin
      wake_sel_d[wake_idx] = writedata[WK_SEL_LSB +: 2];
      wake_req_d[wake_idx] = writedata[WK_REQ_LSB +: 2];
      wake_en_d[wake_idx] = writedata[WK_EN_BIT];
    end
    if (wr_fire && (address == OFS_KEY_ENABLE)) begin
      key_en_d = writedata[N_KEY-1:0];
    end
    if (wr_fire && (address == OFS_REQUEST_CLEAR)) begin
      if (writedata[8:0] == CLR_EXT_GROUP) begin
        wake_pend_d[N_EXT-1:0] = '0;
      end else if (writedata[8:0] == CLR_KEY) begin
        wake_pend_d[N_EXT] = 1'b0;
      end
    end
    for (int w = 0; w < N_WAKE; w++) begin
      if (wake_hit[w] && (wake_req_q[w] == REQ_ACTIVE)) begin
        wake_pend_d[w] = 1'b1;
      end
    end
    standby_release_d = |(wake_pend_q & wake_en_q);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wake_sel_q <= '0;
      wake_req_q <= '0;
      wake_en_q <= '0;
      wake_pend_q <= '0;
      key_en_q <= '0;
      standby_release_q <= 1'b0;
    end else begin
      wake_sel_q <= wake_sel_d;
      wake_req_q <= wake_req_d;
      wake_en_q <= wake_en_d;
      wake_pend_q <= wake_pend_d;
      key_en_q <= key_en_d;
      standby_release_q <= standby_release_d;
    end
  end

  // Core side: forwarding, mask level save and restore, DMA trigger.
  always_comb begin
    base_d = base_q;
    mask_d = mask_q;
    stack_d = stack_q;
    sp_d = sp_q;
    in_service_d = in_service_q;
    nested_d = nested_q;
    dma_req_d = '0;
    core_req_d = core_req_q;
    if (wr_fire && (address == OFS_VECTOR)) begin
      base_d = writedata[31:VB_BASE_LSB];
    end
    if (wr_fire && (address == OFS_CONTROL)) begin
      nested_d = writedata[CT_NEST_BIT];
    end
    if (core_ack && core_req_q.irq) begin
      // The accepted level becomes the mask; the old one is saved unless the stack already holds eight.
      if (sp_q < SP_W'(STACK_DEPTH)) begin
        stack_d[sp_q[2:0]] = mask_q;
        sp_d = sp_q + 4'h1;
      end
      mask_d = core_req_q.level;
      in_service_d = 1'b1;
      dma_req_d.start = dma_en_q[core_req_q.vector[8:2]];
      dma_req_d.source = core_req_q.vector[8:2];
    end else if (wr_fire && (address == OFS_LEVEL)) begin
      if (writedata[LVL_W-1:0] == LVL_OFF) begin
        // Restore the mask that stood before this exception.
        if (sp_q != 4'h0) begin
          mask_d = stack_q[3'(sp_q - 4'h1)];
          sp_d = sp_q - 4'h1;
          in_service_d = (sp_q != 4'h1);
        end else begin
          mask_d = LVL_OFF;
          in_service_d = 1'b0;
        end
      end else begin
        mask_d = writedata[LVL_W-1:0];
      end
    end
    // Forward only above the mask, and only if not blocked by service.
    core_req_d.irq = found && (best_level > mask_q)
                     && (!in_service_q || nested_q) && !(core_ack && core_req_q.irq);
    if (core_req_d.irq) begin
      core_req_d.level = best_level;
      core_req_d.vector = {best_idx, 2'b00};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      base_q <= '0;
      mask_q <= LVL_OFF;
      stack_q <= '0;
      sp_q <= 4'h0;
      in_service_q <= 1'b0;
      nested_q <= 1'b0;
      core_req_q <= '0;
      dma_req_q <= '0;
    end else begin
      base_q <= base_d;
      mask_q <= mask_d;
      stack_q <= stack_d;
      sp_q <= sp_d;
      in_service_q <= in_service_d;
      nested_q <= nested_d;
      core_req_q <= core_req_d;
      dma_req_q <= dma_req_d;
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;
  assign core_req = core_req_q;
  assign dma_req = dma_req_q;
  assign standby_release = standby_release_q;
endmodule // irq_ctrl

// file: logic/irq_ctrl_pkg.sv
// How it works
// - Each source holds a three-bit priority level.
// - Level zero disables a source entirely; the code only blocks forwarding, its pending flag still sets.
// - Each source gets its own vector offset.
// - Pins, key wakeup and 51 peripherals.
// - Accepted interrupt may start a DMA transfer.
// - Controller detect offers low level, high level, falling edge, rising edge.
// - Standby detector selects four modes, active.
// - Detect field 01 means high level.
// - Release enable bit lets pin end stop.
// - Clear codes drop standby pending per group.
// - Key request 01 plus enable releases standby.
// - Eight key enables gate key wakeup inputs.
// - Writing read vector clears that source pending.
// - Mask level zero restores previous mask.
// - Block new interrupts in service unless nested.
// - Nonzero software level write raises source zero.
package irq_ctrl_pkg;
  // Source population: software set, pins, key wakeup, peripherals.
  localparam int N_EXT = 12;
  localparam int N_KEY = 8;
  localparam int N_PERIPH = 51;
  localparam int N_SRC = 1 + N_EXT + 1 + N_PERIPH;
  localparam int N_WAKE = N_EXT + 1;
  localparam int SRC_EXT0 = 1;
  localparam int SRC_KEY = SRC_EXT0 + N_EXT;
  localparam int SRC_PER0 = SRC_KEY + 1;
  localparam int IDX_W = 7;
  localparam int LVL_W = 3;
  localparam int VEC_W = 9;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 4;
  // Register byte offsets; source words sit at SRC_BASE plus four per source.
  localparam logic [11:0] OFS_SRC_BASE = 12'h000;
  localparam logic [11:0] OFS_VECTOR = 12'h200;
  localparam logic [11:0] OFS_FACTOR_CLEAR = 12'h204;
  localparam logic [11:0] OFS_LEVEL = 12'h208;
  localparam logic [11:0] OFS_CONTROL = 12'h20C;
  localparam logic [11:0] OFS_REQUEST_CLEAR = 12'h210;
  localparam logic [11:0] OFS_KEY_ENABLE = 12'h214;
  localparam logic [11:0] OFS_WAKE_BASE = 12'h300;
  // Source control word layout.
  localparam int SC_LEVEL_LSB = 0;
  localparam int SC_DETECT_LSB = 4;
  localparam int SC_DMA_BIT = 8;
  localparam int SC_PEND_BIT = 12;
  // Standby release control word layout.
  localparam int WK_SEL_LSB = 0;
  localparam int WK_REQ_LSB = 2;
  localparam int WK_EN_BIT = 4;
  localparam int WK_PEND_BIT = 8;
  // Control register layout.
  localparam int CT_NEST_BIT = 0;
  localparam int CT_INSVC_BIT = 8;
  localparam int VB_BASE_LSB = 9;
  // Detection mode codes, shared by both detector sides.
  localparam logic [1:0] DET_LOW = 2'h0;
  localparam logic [1:0] DET_HIGH = 2'h1;
  localparam logic [1:0] DET_FALL = 2'h2;
  localparam logic [1:0] DET_RISE = 2'h3;
  localparam logic [1:0] REQ_ACTIVE = 2'h1;
  // Standby pending clear codes.
  localparam logic [8:0] CLR_EXT_GROUP = 9'h004;
  localparam logic [8:0] CLR_KEY = 9'h034;
  localparam logic [LVL_W-1:0] LVL_OFF = 3'h0;
  // Request presented to the processor core.
  typedef struct packed {
    logic irq;
    logic [LVL_W-1:0] level;
    logic [VEC_W-1:0] vector;
  } core_req_t;
  // DMA start trigger.
  typedef struct packed {
    logic start;
    logic [IDX_W-1:0] source;
  } dma_req_t;
endpackage

// file: logic/irq_detect.sv
`timescale 1ns/10ps
// Turns one request line into a hit under a chosen detection mode.
module irq_detect
  import irq_ctrl_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic sample,
  input wire logic [1:0] mode,
  output logic hit
);
  logic prev_q; // Sample seen one cycle earlier.
  logic prev_d; // Next value of the earlier sample.

  // The earlier sample simply follows the line.
  always_comb begin
    prev_d = sample;
  end

  // Reset to low so a line high at release counts as a rising edge.
  always_ff @(posedge clock) begin
    if (reset) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  // Low, high, falling or rising edge, as the mode asks.
  always_comb begin
    case (mode)
      DET_LOW: hit = !sample;
      DET_HIGH: hit = sample;
      DET_FALL: hit = prev_q && !sample;
      DET_RISE: hit = !prev_q && sample;
      default: hit = 1'b0;
    endcase
  end
endmodule // irq_detect

// file: logic/irq_arbiter.sv
`timescale 1ns/10ps
// Finds the pending source with the highest level; lowest index wins a tie.
module irq_arbiter
  import irq_ctrl_pkg::*;
(
  input wire logic [N_SRC-1:0] pending,
  input wire logic [N_SRC-1:0][LVL_W-1:0] level,
  output logic found,
  output logic [IDX_W-1:0] best_idx,
  output logic [LVL_W-1:0] best_level
);
  // A linear scan is slow but small; 65 entries fit easily at 25 MHz.
  always_comb begin
    found = 1'b0;
    best_idx = '0;
    best_level = LVL_OFF;
    for (int i = 0; i < N_SRC; i++) begin
      // Level zero never competes, since strictly greater is required.
      if (pending[i] && (level[i] > best_level)) begin
        found = 1'b1;
        best_idx = IDX_W'(i);
        best_level = level[i];
      end
    end
  end
endmodule // irq_arbiter

// file: verif/irq_ctrl_props.sv
`timescale 1ns/10ps
// Checker on the top-level ports of the interrupt controller.
module irq_ctrl_props
  import irq_ctrl_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic core_ack,
  input wire core_req_t core_req,
  input wire dma_req_t dma_req,
  input wire logic standby_release
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Reset must be seen even while it is asserted, so this one has no disable.
  reset_idle_a: assert property (disable iff (1'b0) reset |=> waitrequest && !core_req.irq
    && !dma_req.start && !standby_release) else $error("outputs not idle after reset");
  bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus access not answered after one wait cycle");
  bus_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  unmapped_zero_a: assert property (read && !waitrequest && address == 12'h180
    |-> readdata == 32'h0) else $error("unmapped read not zero");
  level_live_a: assert property (core_req.irq |-> core_req.level != LVL_OFF)
    else $error("request forwarded at level zero");
  vector_form_a: assert property (core_req.irq |-> core_req.vector[1:0] == 2'h0
    && core_req.vector < 9'h104) else $error("vector outside source table");
  ack_drop_a: assert property (core_ack && core_req.irq |=> !core_req.irq)
    else $error("request still raised after acknowledge");
  dma_cause_a: assert property (dma_req.start |-> $past(core_ack) && $past(core_req.irq)
    && {dma_req.source, 2'h0} == $past(core_req.vector)) else $error("dma start without ack");
endmodule // irq_ctrl_props
bind irq_ctrl irq_ctrl_props irq_ctrl_props_inst (.clock(clock), .reset(reset),
  .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .core_ack(core_ack), .core_req(core_req), .dma_req(dma_req),
  .standby_release(standby_release));

// file: verif/core_model.sv
`timescale 1ns/10ps
// Behavioural core: takes a raised request after a chosen number of cycles.
module core_model
  import irq_ctrl_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire core_req_t core_req,
  input wire logic mask_open,
  input wire logic [3:0] latency,
  output logic core_ack
);
  logic [3:0] wait_q; // Cycles the request has been seen.
  logic [3:0] wait_d;
  logic ack_d;
  // The core only takes requests once software opened its mask bits.
  always_comb begin
    wait_d = 4'h0;
    ack_d = 1'b0;
    if (mask_open && core_req.irq && !core_ack) begin
      if (wait_q == latency) begin
        ack_d = 1'b1;
      end else begin
        wait_d = wait_q + 4'h1;
      end
    end
  end
  // Ack is one cycle long, so a request is never taken twice.
  always_ff @(posedge clock) begin
    if (reset) begin
      wait_q <= 4'h0;
      core_ack <= 1'b0;
    end else begin
      wait_q <= wait_d;
      core_ack <= ack_d;
    end
  end
endmodule // core_model

// file: verif/tb_top.sv
`timescale 1ns/10ps
// Bench: software on the bus, a core model, stimulus on the request pins.
module tb_top;
  import irq_ctrl_pkg::*;
  typedef struct {int src; logic [2:0] lvl; logic [1:0] det; logic [3:0] lat;} row_t;
  logic clock, reset, read, write, waitrequest, standby_release, core_ack, mask_open;
  logic [11:0] address;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable, lat;
  logic [N_EXT-1:0] ext_pins;
  logic [N_KEY-1:0] key_pins;
  logic [N_PERIPH-1:0] periph_irq;
  core_req_t core_req;
  dma_req_t dma_req;
  logic [IDX_W-1:0] got_src;
  int n_fail, tests_run;
  // Source, level, detect mode, core delay.
  row_t rows [6] = '{'{14, 3'h3, DET_LOW, 4'h0}, '{64, 3'h7, DET_LOW, 4'h3},
    '{40, 3'h1, DET_LOW, 4'h1}, '{1, 3'h2, DET_RISE, 4'h1}, '{12, 3'h6, DET_HIGH, 4'h0},
    '{13, 3'h5, DET_HIGH, 4'h2}};
  irq_ctrl irq_ctrl_inst (.clock(clock), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .ext_pins(ext_pins), .key_pins(key_pins),
    .periph_irq(periph_irq), .core_ack(core_ack), .core_req(core_req), .dma_req(dma_req),
    .standby_release(standby_release));
  core_model core_model_inst (.clock(clock), .reset(reset), .core_req(core_req),
    .mask_open(mask_open), .latency(lat), .core_ack(core_ack));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus access; the request is held until waitrequest is seen low.
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    // Waitrequest and read data are both taken at the rising edge that completes the access.
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      n_fail++;
      report_and_stop();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(nm, q & m, e);
  endtask
  // Waits for irq (0), dma start (1), standby release (2) or core ack (3).
  task wait_sig(input int w);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while ((w == 0 ? core_req.irq : w == 1 ? dma_req.start : w == 2 ? standby_release
      : core_ack) !== 1'b1 && n < 40);
    got_src = dma_req.source;
    check("wait done", 32'(n < 40), 32'h1);
    if (n >= 40) report_and_stop();
  endtask
  // Pulses one source for four cycles; peripherals idle high and fall to request.
  task fire(input int s);
    @(posedge clock);
    if (s >= SRC_PER0) periph_irq[s - SRC_PER0] <= 1'b0;
    else if (s == SRC_KEY) key_pins[7] <= 1'b1;
    else ext_pins[s - SRC_EXT0] <= 1'b1;
    repeat (4) @(posedge clock);
    periph_irq <= '1;
    key_pins <= '0;
    ext_pins <= '0;
  endtask
  task take(input int w);
    @(posedge clock);
    mask_open <= 1'b1;
    wait_sig(w);
    @(posedge clock);
    mask_open <= 1'b0;
  endtask
  function automatic logic [11:0] sa(input int s);
    return OFS_SRC_BASE + 12'(4 * s);
  endfunction
  initial begin
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 12'h000;
    writedata = 32'h0;
    byteenable = 4'hF;
    ext_pins = '0;
    key_pins = '0;
    periph_irq = '1;
    mask_open = 1'b0;
    lat = 4'h0;
    n_fail = 0;
    tests_run = 0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    rdchk("control reset", OFS_CONTROL, 32'hFFFF_FFFF, 32'h0);
    bus(1'b1, 12'h180, 32'hFFFF_FFFF);
    rdchk("unmapped", 12'h180, 32'hFFFF_FFFF, 32'h0);
    bus(1'b1, OFS_VECTOR, 32'h0001_0000);
    rdchk("table base", OFS_VECTOR, 32'hFFFF_FE00, 32'h0001_0000);
    bus(1'b1, OFS_KEY_ENABLE, 32'h80);
    $display("register test done");
    foreach (rows[i]) begin
      bus(1'b1, sa(rows[i].src), 32'h100 | {26'h0, rows[i].det, 1'b0, rows[i].lvl});
      // Drop anything caught under the reset detect mode, so only the pulse below can request.
      bus(1'b1, OFS_FACTOR_CLEAR, 32'(4 * rows[i].src));
      fire(rows[i].src);
      wait_sig(0);
      check("vector", 32'(core_req.vector), 32'(4 * rows[i].src));
      check("level", 32'(core_req.level), 32'(rows[i].lvl));
      lat <= rows[i].lat;
      take(1);
      check("dma source", 32'(got_src), 32'(rows[i].src));
      rdchk("mask pushed", OFS_LEVEL, 32'h7, 32'(rows[i].lvl));
      bus(1'b0, OFS_VECTOR, 32'h0);
      check("vector reg", q & 32'h1FF, 32'(4 * rows[i].src));
      bus(1'b1, OFS_FACTOR_CLEAR, q & 32'h1FF);
      rdchk("pending", sa(rows[i].src), 32'h1000, 32'h0);
      bus(1'b1, OFS_LEVEL, 32'h0);
      rdchk("mask popped", OFS_LEVEL, 32'h7, 32'h0);
      rdchk("in service", OFS_CONTROL, 32'h100, 32'h0);
      bus(1'b1, sa(rows[i].src), 32'h0);
      $display("row %0d done", i);
    end
    // A level-zero source never reaches the core.
    fire(33);
    repeat (4) @(negedge clock);
    check("disabled", 32'(core_req.irq), 32'h0);
    // Higher level wins; a third source waits while in service unless nesting is on.
    bus(1'b1, sa(30), 32'h3);
    bus(1'b1, sa(31), 32'h5);
    bus(1'b1, sa(32), 32'h7);
    fire(30);
    fire(31);
    wait_sig(0);
    check("winner", 32'(core_req.vector), 32'(4 * 31));
    take(3);
    bus(1'b1, OFS_FACTOR_CLEAR, 32'(4 * 31));
    fire(32);
    repeat (4) @(negedge clock);
    check("held off", 32'(core_req.irq), 32'h0);
    bus(1'b1, OFS_CONTROL, 32'h1);
    wait_sig(0);
    check("nested", 32'(core_req.vector), 32'(4 * 32));
    take(3);
    bus(1'b1, OFS_FACTOR_CLEAR, 32'(4 * 32));
    bus(1'b1, OFS_LEVEL, 32'h0);
    rdchk("mask back", OFS_LEVEL, 32'h7, 32'h5);
    bus(1'b1, OFS_LEVEL, 32'h0);
    wait_sig(0);
    check("low level", 32'(core_req.vector), 32'(4 * 30));
    bus(1'b1, OFS_FACTOR_CLEAR, 32'(4 * 30));
    bus(1'b1, OFS_CONTROL, 32'h0);
    $display("priority test done");
    // Software-set source.
    bus(1'b1, sa(0), 32'h2);
    wait_sig(0);
    check("software set", 32'(core_req.vector), 32'h0);
    bus(1'b1, OFS_FACTOR_CLEAR, 32'h0);
    repeat (2) @(negedge clock);
    check("software clear", 32'(core_req.irq), 32'h0);
    bus(1'b1, sa(0), 32'h0);
    // Standby release from a pin, then from the keys.
    bus(1'b1, OFS_WAKE_BASE + 12'h00C, 32'h17);
    bus(1'b1, OFS_REQUEST_CLEAR, 32'h004);
    fire(4);
    wait_sig(2);
    rdchk("wake pending", OFS_WAKE_BASE + 12'h00C, 32'h100, 32'h100);
    bus(1'b1, OFS_REQUEST_CLEAR, 32'h004);
    repeat (2) @(negedge clock);
    check("pin wake clear", 32'(standby_release), 32'h0);
    bus(1'b1, OFS_WAKE_BASE + 12'h030, 32'h15);
    @(posedge clock);
    key_pins <= 8'h01;
    repeat (6) @(negedge clock);
    check("masked key", 32'(standby_release), 32'h0);
    @(posedge clock);
    key_pins <= 8'h80;
    wait_sig(2);
    @(posedge clock);
    key_pins <= 8'h00;
    repeat (4) @(posedge clock);
    bus(1'b1, OFS_REQUEST_CLEAR, 32'h034);
    repeat (2) @(negedge clock);
    check("key wake clear", 32'(standby_release), 32'h0);
    $display("standby test done");
    report_and_stop();
  end
endmodule // tb_top
